// ===== hdl/umask_pkg.sv
// constants for the user access mask and processor identification bank
// assumes a single 10 MHz clock domain shared by all users of the bank
package umask_pkg;
   // user access mask field positions
   localparam int UM_WIDTH = 6;
   localparam int UM_RSV_BIT = 0;
   localparam int UM_BYTE_ORDER_BIT = 1;
   localparam int UM_PERF_USER_BIT = 2;
   localparam int UM_ALIGN_BIT = 3;
   localparam int UM_FP_LOW_BIT = 4;
   localparam int UM_FP_HIGH_BIT = 5;
   localparam logic [5:0] UM_RESET = 6'h00;

   // floating-point register ranges tracked by the modified flags
   localparam logic [6:0] FP_LOW_FIRST = 7'h02;
   localparam logic [6:0] FP_LOW_LAST = 7'h1f;
   localparam logic [6:0] FP_HIGH_FIRST = 7'h20;

   // privilege levels
   localparam logic [1:0] PL_MOST = 2'h0;

   // identification register indices
   localparam logic [7:0] ID_VENDOR_LOW = 8'h00;
   localparam logic [7:0] ID_VENDOR_HIGH = 8'h01;
   localparam logic [7:0] ID_IGNORED = 8'h02;
   localparam logic [7:0] ID_VERSION = 8'h03;
   localparam logic [7:0] ID_FEATURES = 8'h04;
   localparam logic [7:0] ID_FIXED_LAST = 8'h04;

   // version register field positions
   localparam int VER_LAST_INDEX_LSB = 0;
   localparam int VER_REVISION_LSB = 8;
   localparam int VER_MODEL_LSB = 16;
   localparam int VER_FAMILY_LSB = 24;
   localparam int VER_ARCH_REV_LSB = 32;

   // feature flag positions
   localparam int FEAT_LONG_BRANCH_BIT = 0;
   localparam int FEAT_SPONT_DEFER_BIT = 1;

   // performance monitor data registers
   localparam int PMD_COUNT_DEF = 4;
   localparam logic [63:0] PMD_RESET = 64'h0;
endpackage

// ===== hdl/cpuid_if.sv
// lookup path between the bank top and the identification file
// assumes the responder answers combinationally in the same cycle
`timescale 1ns/1ps
interface cpuid_if;
   logic [7:0] idx;
   logic [63:0] data;
   logic fault;
   modport requester (output idx, input data, input fault);
   modport responder (input idx, output data, output fault);
endinterface // cpuid_if

// ===== hdl/cpuid_file.sv
// read-only processor identification file, pure lookup
// assumes the requester registers data and fault itself
`timescale 1ns/1ps
module cpuid_file #(
   parameter int LAST_INDEX = 4,
   // vendor values are arbitrary neutral ascii, first character in byte 0
   parameter logic [63:0] VENDOR_LOW = 64'h0000_0000_656d_6341,
   parameter logic [63:0] VENDOR_HIGH = 64'h0,
   parameter logic [7:0] REVISION = 8'h00,
   parameter logic [7:0] MODEL = 8'h00,
   parameter logic [7:0] FAMILY = 8'h00,
   parameter logic [7:0] ARCH_REV = 8'h00,
   parameter logic LONG_BRANCH = 1'b1,
   parameter logic SPONT_DEFER = 1'b0
) (
   cpuid_if.responder id
);
   // never below the fixed region, whatever the parameter says
   localparam logic [7:0] LAST_EFF = (LAST_INDEX < 4) ? umask_pkg::ID_FIXED_LAST
                                                     : 8'(LAST_INDEX);
   logic [63:0] version;
   logic [63:0] features;

   always_comb
   begin
      version = 64'h0;
      version[umask_pkg::VER_LAST_INDEX_LSB +: 8] = LAST_EFF;
      version[umask_pkg::VER_REVISION_LSB +: 8] = REVISION;
      version[umask_pkg::VER_MODEL_LSB +: 8] = MODEL;
      version[umask_pkg::VER_FAMILY_LSB +: 8] = FAMILY;
      version[umask_pkg::VER_ARCH_REV_LSB +: 8] = ARCH_REV;
   end

   always_comb
   begin
      features = 64'h0;
      features[umask_pkg::FEAT_LONG_BRANCH_BIT] = LONG_BRANCH;
      features[umask_pkg::FEAT_SPONT_DEFER_BIT] = SPONT_DEFER;
   end

   always_comb
   begin
      id.fault = (id.idx > LAST_EFF);
      case (id.idx)
         umask_pkg::ID_VENDOR_LOW: id.data = VENDOR_LOW;
         umask_pkg::ID_VENDOR_HIGH: id.data = VENDOR_HIGH;
         umask_pkg::ID_IGNORED: id.data = 64'h0;
         umask_pkg::ID_VERSION: id.data = version;
         umask_pkg::ID_FEATURES: id.data = features;
         // variable region holds nothing here
         default: id.data = 64'h0;
      endcase
   end
endmodule // cpuid_file

// ===== hdl/user_mask_bank.sv
// user access mask, performance monitor data access and identification reads
// assumes all request inputs come from core logic on clk, one request per kind
// What this block does
// - privileged code can make monitor data readable at any privilege level
// - secured counters read zero at every privilege level
// - monitor data writes only succeed at the most privileged level
// - mask bit 1 picks data byte order, never for stack engine accesses
// - legacy 32-bit data accesses ignore byte order, always little-endian
// - mask bit 2 enables user performance monitors for both instruction sets
// - mask bit 3 set makes every unaligned data reference fault
// - completing write to f2..f31 sets mask bit 4
// - completing write to f32..f127 sets mask bit 5
// - both modified flags stay set until software writes the mask
// - identification file: fixed indices 0..4, variable from 5, 8 bytes each
// - index above last-index field raises reserved register fault
// - identification reads need no privilege, writes are refused
// - registers 0 and 1 hold vendor ascii, first characters lowest
// - identification register 2 always reads zero
// - register 3 holds last index, revision, model, family, architecture revision
// - last index is implemented count minus one, at least 4
// - register 4 bits read one for supported features
// - register 4 bit 0 long branch, bit 1 spontaneous deferral
`timescale 1ns/1ps
module user_mask_bank #(
   parameter int PMD_COUNT = umask_pkg::PMD_COUNT_DEF,
   parameter int PMD_IDX_W = 2,
   parameter int LAST_INDEX = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [1:0] cpl,
   input wire logic um_wr_valid,
   input wire logic [5:0] um_wr_data,
   input wire logic fp_wr_valid,
   input wire logic [6:0] fp_wr_reg,
   input wire logic perf_event,
   input wire logic pmd_cfg_valid,
   input wire logic pmd_cfg_user_ok,
   input wire logic pmd_cfg_secure,
   input wire logic pmd_wr_valid,
   input wire logic [PMD_IDX_W-1:0] pmd_wr_idx,
   input wire logic [63:0] pmd_wr_data,
   input wire logic pmd_rd_valid,
   input wire logic [PMD_IDX_W-1:0] pmd_rd_idx,
   input wire logic id_rd_valid,
   input wire logic id_wr_valid,
   input wire logic [7:0] id_idx,
   input wire logic mem_valid,
   input wire logic mem_legacy,
   input wire logic mem_rse,
   input wire logic [2:0] mem_size_log2,
   input wire logic [3:0] mem_addr_low,
   output logic [5:0] user_access_mask_q,
   output logic byte_order_select_q,
   output logic perf_user_enable_q,
   output logic alignment_check_q,
   output logic [63:0] pmd_rd_data_q,
   output logic pmd_rd_done_q,
   output logic priv_fault_q,
   output logic [63:0] id_rd_data_q,
   output logic id_rd_done_q,
   output logic reserved_fault_q,
   output logic mem_done_q,
   output logic mem_big_endian_q,
   output logic unaligned_fault_q
);
   typedef struct packed {
      logic [5:0] um;
      logic pmd_user_ok;
      logic pmd_secure;
      logic [PMD_COUNT-1:0][63:0] perf_monitor_data;
      logic [63:0] pmd_rd_data;
      logic pmd_rd_done;
      logic priv_fault;
      logic [63:0] id_rd_data;
      logic id_rd_done;
      logic reserved_fault;
      logic mem_done;
      logic mem_big_endian;
      logic unaligned_fault;
   } state_s;

   state_s st_q;
   state_s st_d;
   logic fp_low_hit;
   logic fp_high_hit;
   logic privileged;
   logic [3:0] align_mask;
   logic misaligned;

   cpuid_if id_bus ();

   cpuid_file #(
      .LAST_INDEX(LAST_INDEX)
   ) u_cpuid_file (
      .id(id_bus.responder)
   );

   assign id_bus.idx = id_idx;
   assign privileged = (cpl == umask_pkg::PL_MOST);
   assign fp_low_hit = fp_wr_valid && (fp_wr_reg >= umask_pkg::FP_LOW_FIRST)
                       && (fp_wr_reg <= umask_pkg::FP_LOW_LAST);
   assign fp_high_hit = fp_wr_valid && (fp_wr_reg >= umask_pkg::FP_HIGH_FIRST);
   // sizes above 16 bytes are not issued by the core
   assign align_mask = ~(4'hf << mem_size_log2);
   assign misaligned = |(mem_addr_low & align_mask);

   always_comb
   begin
      st_d = st_q;
      st_d.pmd_rd_done = 1'b0;
      st_d.priv_fault = 1'b0;
      st_d.id_rd_done = 1'b0;
      st_d.reserved_fault = 1'b0;
      st_d.mem_done = 1'b0;
      st_d.unaligned_fault = 1'b0;

      if (um_wr_valid)
      begin
         st_d.um = um_wr_data;
         st_d.um[umask_pkg::UM_RSV_BIT] = 1'b0;
      end
      if (fp_low_hit)
      begin
         st_d.um[umask_pkg::UM_FP_LOW_BIT] = 1'b1;
      end
      if (fp_high_hit)
      begin
         st_d.um[umask_pkg::UM_FP_HIGH_BIT] = 1'b1;
      end

      if (perf_event && st_q.um[umask_pkg::UM_PERF_USER_BIT])
      begin
         st_d.perf_monitor_data[0] = st_q.perf_monitor_data[0] + 64'h1;
      end

      if (pmd_cfg_valid)
      begin
         if (privileged)
         begin
            st_d.pmd_user_ok = pmd_cfg_user_ok;
            st_d.pmd_secure = pmd_cfg_secure;
         end
         else
         begin
            st_d.priv_fault = 1'b1;
         end
      end

      if (pmd_wr_valid)
      begin
         if (privileged)
         begin
            st_d.perf_monitor_data[pmd_wr_idx] = pmd_wr_data;
         end
         else
         begin
            st_d.priv_fault = 1'b1;
         end
      end

      if (pmd_rd_valid)
      begin
         st_d.pmd_rd_done = 1'b1;
         if (st_q.pmd_secure)
         begin
            st_d.pmd_rd_data = 64'h0;
         end
         else if (!privileged && !st_q.pmd_user_ok)
         begin
            st_d.pmd_rd_data = 64'h0;
            st_d.priv_fault = 1'b1;
         end
         else
         begin
            st_d.pmd_rd_data = st_q.perf_monitor_data[pmd_rd_idx];
         end
      end

      if (id_rd_valid)
      begin
         st_d.id_rd_done = 1'b1;
         // fault on out of range index
         st_d.reserved_fault = id_bus.fault;
         st_d.id_rd_data = id_bus.fault ? 64'h0 : id_bus.data;
      end
      else if (id_wr_valid)
      begin
         st_d.id_rd_done = 1'b1;
         st_d.reserved_fault = 1'b1;
         st_d.id_rd_data = 64'h0;
      end

      if (mem_valid)
      begin
         st_d.mem_done = 1'b1;
         st_d.mem_big_endian = st_q.um[umask_pkg::UM_BYTE_ORDER_BIT] && !mem_legacy
                               && !mem_rse && (mem_size_log2 != 3'h0);
         st_d.unaligned_fault = st_q.um[umask_pkg::UM_ALIGN_BIT] && misaligned;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= '0;
         st_q.um <= umask_pkg::UM_RESET;
      end
      else if (ce)
      begin
         st_q <= st_d;
      end
   end

   assign user_access_mask_q = st_q.um;
   assign byte_order_select_q = st_q.um[umask_pkg::UM_BYTE_ORDER_BIT];
   assign perf_user_enable_q = st_q.um[umask_pkg::UM_PERF_USER_BIT];
   assign alignment_check_q = st_q.um[umask_pkg::UM_ALIGN_BIT];
   assign pmd_rd_data_q = st_q.pmd_rd_data;
   assign pmd_rd_done_q = st_q.pmd_rd_done;
   assign priv_fault_q = st_q.priv_fault;
   assign id_rd_data_q = st_q.id_rd_data;
   assign id_rd_done_q = st_q.id_rd_done;
   assign reserved_fault_q = st_q.reserved_fault;
   assign mem_done_q = st_q.mem_done;
   assign mem_big_endian_q = st_q.mem_big_endian;
   assign unaligned_fault_q = st_q.unaligned_fault;

   // checks, frozen cycles excluded through ce in each antecedent except a_fp_flag_sticky
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_fp_low_set: assert property (ce && fp_low_hit |=> user_access_mask_q[4])
      else $error("low fp flag not set");
   a_fp_high_set: assert property (ce && fp_high_hit |=> user_access_mask_q[5])
      else $error("high fp flag not set");
   a_fp_flag_sticky: assert property (user_access_mask_q[4] && !(ce && um_wr_valid)
      |=> user_access_mask_q[4])
      else $error("low fp flag dropped without write");
   // secured read returns zero
   // refused writes or configs in the same cycle raise their own fault
   a_secure_read_zero: assert property (ce && pmd_rd_valid && st_q.pmd_secure
      && !pmd_wr_valid && !pmd_cfg_valid
      |=> pmd_rd_done_q && (pmd_rd_data_q == 64'h0) && !priv_fault_q)
      else $error("secured counter read not zero");
   a_pmd_write_priv: assert property (ce && pmd_wr_valid && !privileged
      && !(perf_event && perf_user_enable_q)
      |=> priv_fault_q && $stable(st_q.perf_monitor_data))
      else $error("unprivileged monitor write took effect");
   a_user_read_ok: assert property (ce && pmd_rd_valid && !st_q.pmd_secure
      && st_q.pmd_user_ok && !pmd_wr_valid && !pmd_cfg_valid
      |=> pmd_rd_done_q && !priv_fault_q)
      else $error("configured user read faulted");
   a_legacy_little: assert property (ce && mem_valid && mem_legacy
      |=> mem_done_q && !mem_big_endian_q)
      else $error("legacy access went big-endian");
   a_byte_order: assert property (ce && mem_valid && !mem_legacy && !mem_rse
      && (mem_size_log2 != 3'h0) |=> mem_big_endian_q == $past(byte_order_select_q))
      else $error("byte order does not follow mask");
   a_align_fault: assert property (ce && mem_valid && alignment_check_q && misaligned
      |=> unaligned_fault_q)
      else $error("unaligned reference did not fault");
   a_id_range_fault: assert property (ce && id_rd_valid && (id_idx > 8'(LAST_INDEX))
      && (id_idx > umask_pkg::ID_FIXED_LAST)
      |=> reserved_fault_q && (id_rd_data_q == 64'h0))
      else $error("out of range id read did not fault");
   a_id_slot_zero: assert property (ce && id_rd_valid && (id_idx == umask_pkg::ID_IGNORED)
      |=> id_rd_done_q && (id_rd_data_q == 64'h0) && !reserved_fault_q)
      else $error("ignored id slot not zero");
   a_id_last_index: assert property (ce && id_rd_valid && (id_idx == umask_pkg::ID_VERSION)
      |=> id_rd_data_q[7:0] >= umask_pkg::ID_FIXED_LAST)
      else $error("last index field below four");
   a_perf_enable: assert property (ce && um_wr_valid
      |=> perf_user_enable_q == $past(um_wr_data[2]))
      else $error("monitor enable not written");

   c_fp_low_flag: cover property (ce && fp_low_hit ##1 user_access_mask_q[4]);
   c_secure_read: cover property (ce && pmd_rd_valid && st_q.pmd_secure);
   c_id_fault: cover property (ce && id_rd_valid ##1 reserved_fault_q);
   c_unaligned: cover property (ce && mem_valid ##1 unaligned_fault_q);
endmodule // user_mask_bank

// ===== verification/testbench.sv
// self-checking bench for the user access mask bank, a cycle model compared at every falling edge
// assumes one answer cycle after the taking edge and inputs driven at the falling edge
`timescale 1ns/1ps
module testbench;
   localparam int LAST = 6;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [1:0] cpl = 2'h0;
   logic um_wr_valid = 1'b0;
   logic [5:0] um_wr_data = 6'h00;
   logic fp_wr_valid = 1'b0;
   logic [6:0] fp_wr_reg = 7'h00;
   logic perf_event = 1'b0;
   logic pmd_cfg_valid = 1'b0;
   logic pmd_cfg_user_ok = 1'b0;
   logic pmd_cfg_secure = 1'b0;
   logic pmd_wr_valid = 1'b0;
   logic [1:0] pmd_wr_idx = 2'h0;
   logic [63:0] pmd_wr_data = 64'h0;
   logic pmd_rd_valid = 1'b0;
   logic [1:0] pmd_rd_idx = 2'h0;
   logic id_rd_valid = 1'b0;
   logic id_wr_valid = 1'b0;
   logic [7:0] id_idx = 8'h00;
   logic mem_valid = 1'b0;
   logic mem_legacy = 1'b0;
   logic mem_rse = 1'b0;
   logic [2:0] mem_size_log2 = 3'h0;
   logic [3:0] mem_addr_low = 4'h0;
   logic [5:0] user_access_mask_q;
   logic byte_order_select_q, perf_user_enable_q, alignment_check_q;
   logic [63:0] pmd_rd_data_q, id_rd_data_q;
   logic pmd_rd_done_q, priv_fault_q, id_rd_done_q, reserved_fault_q;
   logic mem_done_q, mem_big_endian_q, unaligned_fault_q;
   int errors = 0;
   int check_count = 0;
   logic [31:0] lfsr_q = 32'hf63d;
   logic [5:0] m_mask;
   logic [63:0] m_pmd [4];
   logic m_ok, m_sec, id_chk;
   logic [63:0] e_pdata, e_idata;
   logic e_pdone, e_pfault, e_idone, e_rfault, e_mdone, e_mbe, e_ufault;
   logic [6:0] fp_list [6] = '{7'h00, 7'h01, 7'h02, 7'h1f, 7'h20, 7'h7f};

   always #50 clk = ~clk;

   user_mask_bank #(.LAST_INDEX(LAST)) DUT (.clk(clk), .rst(rst), .ce(ce), .cpl(cpl),
      .um_wr_valid(um_wr_valid), .um_wr_data(um_wr_data), .fp_wr_valid(fp_wr_valid),
      .fp_wr_reg(fp_wr_reg), .perf_event(perf_event), .pmd_cfg_valid(pmd_cfg_valid),
      .pmd_cfg_user_ok(pmd_cfg_user_ok), .pmd_cfg_secure(pmd_cfg_secure),
      .pmd_wr_valid(pmd_wr_valid), .pmd_wr_idx(pmd_wr_idx), .pmd_wr_data(pmd_wr_data),
      .pmd_rd_valid(pmd_rd_valid), .pmd_rd_idx(pmd_rd_idx), .id_rd_valid(id_rd_valid),
      .id_wr_valid(id_wr_valid), .id_idx(id_idx), .mem_valid(mem_valid),
      .mem_legacy(mem_legacy), .mem_rse(mem_rse), .mem_size_log2(mem_size_log2),
      .mem_addr_low(mem_addr_low), .user_access_mask_q(user_access_mask_q),
      .byte_order_select_q(byte_order_select_q), .perf_user_enable_q(perf_user_enable_q),
      .alignment_check_q(alignment_check_q), .pmd_rd_data_q(pmd_rd_data_q),
      .pmd_rd_done_q(pmd_rd_done_q), .priv_fault_q(priv_fault_q),
      .id_rd_data_q(id_rd_data_q), .id_rd_done_q(id_rd_done_q),
      .reserved_fault_q(reserved_fault_q), .mem_done_q(mem_done_q),
      .mem_big_endian_q(mem_big_endian_q), .unaligned_fault_q(unaligned_fault_q));

   task automatic roll(output logic [31:0] v);
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      v = lfsr_q;
   endtask

   // vendor bytes and version fields are the bank's neutral defaults
   function automatic logic [63:0] id_val(input logic [7:0] i);
      case (i)
         8'h00: id_val = 64'h0000_0000_656d_6341;
         8'h03: id_val = 64'(LAST);
         8'h04: id_val = 64'h1;
         default: id_val = 64'h0;
      endcase
   endfunction

   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t ns: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cycle;
      @(posedge clk);
      if (rst)
      begin
         m_mask = 6'h00;
         foreach (m_pmd[i]) m_pmd[i] = 64'h0;
         {m_ok, m_sec, e_pdone, e_pfault, e_idone, e_rfault, e_mdone, e_mbe, e_ufault} = '0;
         e_pdata = 64'h0;
         e_idata = 64'h0;
         id_chk = 1'b1;
      end
      else if (ce)
      begin
         {e_pdone, e_pfault, e_idone, e_rfault, e_mdone, e_ufault} = '0;
         if (mem_valid)
         begin
            e_mdone = 1'b1;
            e_mbe = m_mask[1] & ~mem_legacy & ~mem_rse & (mem_size_log2 != 3'h0);
            e_ufault = m_mask[3] && (int'(mem_addr_low) % (1 << mem_size_log2)) != 0;
         end
         if (pmd_rd_valid)
         begin
            e_pdone = 1'b1;
            e_pdata = (!m_sec && (cpl == 2'h0 || m_ok)) ? m_pmd[pmd_rd_idx] : 64'h0;
            e_pfault = !m_sec && cpl != 2'h0 && !m_ok;
         end
         if (perf_event && m_mask[2]) m_pmd[0] = m_pmd[0] + 64'h1;
         if (pmd_wr_valid && cpl != 2'h0) e_pfault = 1'b1;
         else if (pmd_wr_valid) m_pmd[pmd_wr_idx] = pmd_wr_data;
         if (pmd_cfg_valid && cpl != 2'h0) e_pfault = 1'b1;
         else if (pmd_cfg_valid) {m_ok, m_sec} = {pmd_cfg_user_ok, pmd_cfg_secure};
         if (id_rd_valid)
         begin
            {e_idone, id_chk} = 2'b11;
            e_rfault = id_idx > 8'(LAST);
            e_idata = id_val(id_idx);
         end
         else if (id_wr_valid)
         begin
            {e_idone, e_rfault, id_chk} = 3'b111;
            e_idata = 64'h0;
         end
         if (um_wr_valid) m_mask = um_wr_data & 6'h3e;
         if (fp_wr_valid && fp_wr_reg >= 7'h02 && fp_wr_reg <= 7'h1f) m_mask[4] = 1'b1;
         if (fp_wr_valid && fp_wr_reg >= 7'h20) m_mask[5] = 1'b1;
      end
      @(negedge clk);
      check(user_access_mask_q, m_mask, "mask");
      check(byte_order_select_q, m_mask[1], "byte order");
      check(perf_user_enable_q, m_mask[2], "perf enable");
      check(alignment_check_q, m_mask[3], "align check");
      check(pmd_rd_data_q, e_pdata, "monitor data");
      check(pmd_rd_done_q, e_pdone, "monitor done");
      check(priv_fault_q, e_pfault, "priv fault");
      if (id_chk) check(id_rd_data_q, e_idata, "id data");
      check(id_rd_done_q, e_idone, "id done");
      check(reserved_fault_q, e_rfault, "reserved fault");
      check(mem_done_q, e_mdone, "mem done");
      check(mem_big_endian_q, e_mbe, "big endian");
      check(unaligned_fault_q, e_ufault, "unaligned");
   endtask

   task automatic idle;
      {um_wr_valid, fp_wr_valid, perf_event, pmd_cfg_valid, pmd_wr_valid} = '0;
      {pmd_rd_valid, id_rd_valid, id_wr_valid, mem_valid} = '0;
      ce = 1'b1;
   endtask

   // pulse rates chosen so every group is busy; combinations with an open order are avoided
   task automatic drive_random;
      logic [31:0] r, s;
      roll(r);
      roll(s);
      cpl = r[1:0];
      ce = r[4:2] != 3'h0;
      um_wr_valid = r[7:5] == 3'h0;
      um_wr_data = s[5:0];
      fp_wr_valid = r[9:8] == 2'h0;
      fp_wr_reg = s[12:6];
      perf_event = r[10] & ~um_wr_valid;
      pmd_wr_valid = r[12:11] == 2'h0;
      pmd_wr_idx = s[14:13];
      pmd_wr_data = {r, s};
      pmd_rd_valid = r[13] & ~perf_event;
      pmd_rd_idx = s[16:15];
      pmd_cfg_valid = r[16:14] == 3'h0 && !pmd_rd_valid;
      pmd_cfg_user_ok = s[17];
      pmd_cfg_secure = s[18] & s[19];
      id_rd_valid = r[17];
      id_wr_valid = r[19:18] == 2'h0;
      id_idx = (s[23] & s[24]) ? 8'hff : {5'h00, s[22:20]};
      mem_valid = r[20];
      mem_legacy = r[21] & r[22];
      mem_rse = r[23] & r[24];
      mem_size_log2 = s[27:25] % 3'h5;
      mem_addr_low = s[31:28];
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
      begin
         $display("Testbench passed");
      end
      else
      begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial
   begin
      #(6000 * 100);
      errors++;
      tally_and_finish();
   end

   initial
   begin
      repeat (16) cycle();
      rst = 1'b0;
      cycle();
      // all-ones mask write together with each fp write, held one idle cycle, then cleared by a zero mask write
      foreach (fp_list[i])
      begin
         {um_wr_valid, um_wr_data, fp_wr_valid, fp_wr_reg} = {1'b1, 6'h3f, 1'b1, fp_list[i]};
         cycle();
         idle();
         cycle();
         {um_wr_valid, um_wr_data} = {1'b1, 6'h00};
         cycle();
         idle();
      end
      // whole identification range, one past the end and the top index
      for (int i = 0; i < 9; i++)
      begin
         {id_rd_valid, id_idx} = {1'b1, (i == 8) ? 8'hff : 8'(i)};
         cycle();
      end
      {id_rd_valid, id_wr_valid} = 2'b01;
      cycle();
      for (int n = 0; n < 3000; n++)
      begin
         if (n == 1500)
         begin
            idle();
            rst = 1'b1;
            cycle();
            rst = 1'b0;
            cycle();
         end
         drive_random();
         cycle();
      end
      idle();
      cycle();
      tally_and_finish();
   end
endmodule // testbench
